// ---- include/stdac_pkg.sv ----
`default_nettype none
package stdac_pkg;
  localparam int unsigned ADR_W = 8;
  localparam int unsigned DEPTH = 256;
  localparam logic [7:0] OP_READ = 8'ha8;
  localparam logic [7:0] OP_WRITE = 8'ha4;
  localparam logic [7:0] OP_CMD_WRITE_ENABLE = 8'ha3;
  localparam logic [7:0] OP_CMD_WRITE_DISABLE = 8'ha0;
  localparam logic [7:0] OP_CMD_POWER_DOWN_ENTER = 8'hac;
  localparam logic [7:0] OP_CMD_POWER_DOWN_EXIT = 8'ha6;
  localparam logic [7:0] OP_CALL = 8'ha2;
  localparam logic [7:0] ADR_DAC = 8'h00;
  localparam logic [5:0] BIT_OP_LAST = 6'h07;
  localparam logic [5:0] BIT_ADR_LAST = 6'h0f;
  localparam logic [5:0] BIT_RD_FIRST = 6'h11;
  localparam logic [5:0] BIT_DAT_LAST = 6'h1f;
  localparam logic [5:0] BIT_FULL = 6'h20;
  localparam int unsigned CLK_KHZ = 250000;
  localparam int unsigned RESTORE_MS = 2;
  localparam int unsigned RESTORE_CYC = RESTORE_MS * CLK_KHZ;
  localparam int unsigned PROG_MS = 5;
  localparam int unsigned PROG_CYC = PROG_MS * CLK_KHZ;
  localparam int unsigned CNT_W = 21;
  localparam logic RST_WE = 1'b0;
  localparam logic RST_NORMAL = 1'b0;
  localparam logic [7:0] RST_DAC = 8'h00;
  typedef enum logic [2:0] {
    S_WAIT_CS,
    S_RESTORE,
    S_FIRST_LOW,
    S_IDLE,
    S_PROG
  } stdac_state_e;
endpackage
`default_nettype wire

// ---- rtl/stdac_ctrl.sv ----
`timescale 1ns/1ps
`default_nettype none
module stdac_ctrl #(
  parameter int unsigned RESTORE_CYCLES = stdac_pkg::RESTORE_CYC,
  parameter int unsigned PROG_CYCLES = stdac_pkg::PROG_CYC
) (
  input wire logic clk,
  input wire logic rstn,
  input wire logic serial_clock,
  input wire logic chip_select_n,
  input wire logic data_in_pin,
  output logic data_out_pin,
  output logic data_out_oe,
  output logic [7:0] analog_out_0,
  output logic analog_out_0_oe,
  output logic [7:0] analog_out_1,
  output logic analog_out_1_oe
);
  import stdac_pkg::*;

  localparam logic [CNT_W-1:0] RST_LAST = CNT_W'(RESTORE_CYCLES - 1);
  localparam logic [CNT_W-1:0] PROG_LAST = CNT_W'(PROG_CYCLES - 1);

  function automatic logic is_short(input logic [7:0] op);
    is_short = (op == OP_CMD_WRITE_ENABLE) || (op == OP_CMD_WRITE_DISABLE) || (op == OP_CMD_POWER_DOWN_ENTER) ||
               (op == OP_CMD_POWER_DOWN_EXIT) || (op == OP_CALL);
  endfunction

  // Nonvolatile store; no reset, contents survive the block reset
  logic [15:0] mem [0:DEPTH-1];

  // Link side; counters and flags reset by chip select high, payload registers hold
  logic [5:0] cnt_ff;
  logic [14:0] sh_ff;
  logic [7:0] op_ff;
  logic [7:0] adr_ff;
  logic [15:0] dat_ff;
  logic done_ff;
  logic rd_ff;
  logic [3:0] pos_ff;
  logic [ADR_W-1:0] rd_adr_ff;
  logic [15:0] word_ff;
  logic rd_oe_ff;
  logic rd_bit_ff;
  logic blk_s1_ff;
  logic blk_s2_ff;

  // Core side
  logic cs_s1_ff;
  logic cs_s2_ff;
  logic cs_d_ff;
  logic dn_s1_ff;
  logic dn_s2_ff;
  logic dn_d_ff;
  stdac_state_e state_ff;
  stdac_state_e nxt_state;
  logic [CNT_W-1:0] tcnt_ff;
  logic we_ff;
  logic normal_ff;
  logic [7:0] dac0_ff;
  logic [7:0] dac1_ff;
  logic st_oe_ff;
  logic st_rdy_ff;
  logic blk_ff;
  logic cs_fall;
  logic exec;
  logic restore_end;
  logic prog_start;

  always_ff @(posedge serial_clock or posedge chip_select_n) begin
    if (chip_select_n) begin
      cnt_ff <= 6'h00;
    end else if (cnt_ff != BIT_FULL) begin
      cnt_ff <= cnt_ff + 6'h01;
    end
  end

  // Payload freezes once counted in; the core reads it after the done level crosses
  always_ff @(posedge serial_clock) begin
    sh_ff <= {sh_ff[13:0], data_in_pin};
    if (cnt_ff == BIT_OP_LAST) begin
      op_ff <= {sh_ff[6:0], data_in_pin};
    end
    if (cnt_ff == BIT_ADR_LAST) begin
      adr_ff <= {sh_ff[6:0], data_in_pin};
    end
    if (cnt_ff == BIT_DAT_LAST) begin
      dat_ff <= {sh_ff[14:0], data_in_pin};
    end
  end

  always_ff @(posedge serial_clock or posedge chip_select_n) begin
    if (chip_select_n) begin
      done_ff <= 1'b0;
    end else if (!done_ff && !blk_s2_ff) begin
      if (cnt_ff == BIT_ADR_LAST && is_short(op_ff)) begin
        done_ff <= 1'b1;
      end else if (cnt_ff == BIT_DAT_LAST && op_ff == OP_WRITE) begin
        done_ff <= 1'b1;
      end
    end
  end

  // Preset to blocked at each frame start, so a stale level never lets a read out
  always_ff @(posedge serial_clock or posedge chip_select_n) begin
    if (chip_select_n) begin
      blk_s1_ff <= 1'b1;
      blk_s2_ff <= 1'b1;
    end else begin
      blk_s1_ff <= blk_ff;
      blk_s2_ff <= blk_s1_ff;
    end
  end

  always_ff @(posedge serial_clock or posedge chip_select_n) begin
    if (chip_select_n) begin
      rd_ff <= 1'b0;
      pos_ff <= 4'h0;
    end else if (!rd_ff) begin
      if (cnt_ff == BIT_ADR_LAST && op_ff == OP_READ && !blk_s2_ff) begin
        rd_ff <= 1'b1;
      end
    end else begin
      pos_ff <= pos_ff - 4'h1;
    end
  end

  always_ff @(posedge serial_clock) begin
    if (cnt_ff == BIT_ADR_LAST) begin
      rd_adr_ff <= {sh_ff[6:0], data_in_pin};
    end else if (rd_ff && pos_ff == 4'h0) begin
      word_ff <= mem[rd_adr_ff];
      rd_adr_ff <= rd_adr_ff + 8'h01;
    end
  end

  always_ff @(negedge serial_clock or posedge chip_select_n) begin
    if (chip_select_n) begin
      rd_oe_ff <= 1'b0;
      rd_bit_ff <= 1'b0;
    end else begin
      rd_oe_ff <= rd_ff && (cnt_ff >= BIT_RD_FIRST);
      rd_bit_ff <= word_ff[pos_ff];
    end
  end

  always_ff @(posedge clk) begin
    cs_s1_ff <= chip_select_n;
    cs_s2_ff <= cs_s1_ff;
    cs_d_ff <= cs_s2_ff;
    dn_s1_ff <= done_ff;
    dn_s2_ff <= dn_s1_ff;
    dn_d_ff <= dn_s2_ff;
  end

  assign cs_fall = cs_d_ff && !cs_s2_ff;
  assign exec = dn_s2_ff && !dn_d_ff && (state_ff == S_IDLE);
  assign restore_end = (state_ff == S_RESTORE) && (tcnt_ff == RST_LAST);
  assign prog_start = exec && (op_ff == OP_WRITE) && we_ff;

  always_comb begin
    nxt_state = state_ff;
    unique case (state_ff)
      S_WAIT_CS: if (cs_fall) begin
        nxt_state = S_RESTORE;
      end
      S_RESTORE: if (restore_end) begin
        nxt_state = S_FIRST_LOW;
      end
      S_FIRST_LOW: if (cs_s2_ff) begin
        nxt_state = S_IDLE;
      end
      S_IDLE: if (prog_start) begin
        nxt_state = S_PROG;
      end
      S_PROG: if (tcnt_ff == PROG_LAST) begin
        nxt_state = S_IDLE;
      end
      default: nxt_state = S_WAIT_CS;
    endcase
  end

  // Nothing returns to the wait state, so restore happens once per reset
  always_ff @(posedge clk) begin
    if (!rstn) begin
      state_ff <= S_WAIT_CS;
    end else begin
      state_ff <= nxt_state;
    end
  end

  always_ff @(posedge clk) begin
    if (!rstn) begin
      tcnt_ff <= '0;
    end else if (nxt_state != state_ff) begin
      tcnt_ff <= '0;
    end else begin
      tcnt_ff <= tcnt_ff + CNT_W'(1);
    end
  end

  always_ff @(posedge clk) begin
    if (!rstn) begin
      we_ff <= RST_WE;
    end else if (exec && op_ff == OP_CMD_WRITE_ENABLE) begin
      we_ff <= 1'b1;
    end else if (exec && op_ff == OP_CMD_WRITE_DISABLE) begin
      we_ff <= 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    if (!rstn) begin
      normal_ff <= RST_NORMAL;
    end else if (restore_end) begin
      normal_ff <= 1'b1;
    end else if (exec && op_ff == OP_CMD_POWER_DOWN_ENTER) begin
      normal_ff <= 1'b0;
    end else if (exec && op_ff == OP_CMD_POWER_DOWN_EXIT) begin
      normal_ff <= 1'b1;
    end
  end

  // Codes are kept through power-down; only the output enables drop
  always_ff @(posedge clk) begin
    if (!rstn) begin
      dac0_ff <= RST_DAC;
      dac1_ff <= RST_DAC;
    end else if (restore_end) begin
      dac0_ff <= mem[ADR_DAC][15:8];
      dac1_ff <= mem[ADR_DAC][7:0];
    end else if (exec && normal_ff && op_ff == OP_WRITE && adr_ff == ADR_DAC) begin
      dac0_ff <= dat_ff[15:8];
      dac1_ff <= dat_ff[7:0];
    end else if (exec && normal_ff && op_ff == OP_CALL && adr_ff != ADR_DAC) begin
      dac0_ff <= mem[adr_ff][15:8];
      dac1_ff <= mem[adr_ff][7:0];
    end
  end

  always_ff @(posedge clk) begin
    if (prog_start) begin
      mem[adr_ff] <= dat_ff;
    end
  end

  always_ff @(posedge clk) begin
    if (!rstn) begin
      st_oe_ff <= 1'b0;
      st_rdy_ff <= 1'b1;
      blk_ff <= 1'b1;
    end else begin
      if (prog_start) begin
        st_oe_ff <= 1'b1;
      end else if (cs_s2_ff) begin
        st_oe_ff <= 1'b0;
      end
      st_rdy_ff <= (nxt_state != S_PROG);
      blk_ff <= (nxt_state != S_IDLE);
    end
  end

  assign data_out_pin = rd_oe_ff ? rd_bit_ff : st_rdy_ff;
  assign data_out_oe = rd_oe_ff || st_oe_ff;
  assign analog_out_0 = dac0_ff;
  assign analog_out_1 = dac1_ff;
  assign analog_out_0_oe = normal_ff;
  assign analog_out_1_oe = normal_ff;

  sequence s_prog_go;
    exec && op_ff == OP_WRITE && we_ff;
  endsequence

  sequence s_busy_shown;
    state_ff == S_PROG ##1 !st_rdy_ff;
  endsequence

  sequence s_pd_exit;
    exec && op_ff == OP_CMD_POWER_DOWN_EXIT && !normal_ff;
  endsequence

  a_wp_no_prog: assert property (@(posedge clk) disable iff (!rstn)
    exec && op_ff == OP_WRITE && !we_ff |=> state_ff == S_IDLE && mem[adr_ff] === $past(mem[adr_ff]))
    else $error("write programmed while protected");

  a_cmd_write_enable_sets: assert property (@(posedge clk) disable iff (!rstn)
    exec && op_ff == OP_CMD_WRITE_ENABLE |=> we_ff)
    else $error("write enable not taken");

  a_we_hold: assert property (@(posedge clk) disable iff (!rstn)
    we_ff && !(exec && op_ff == OP_CMD_WRITE_DISABLE) |=> we_ff)
    else $error("write permission lost");

  a_pwrup_state: assert property (@(posedge clk) disable iff (!rstn)
    state_ff == S_WAIT_CS |-> !we_ff && !normal_ff && !analog_out_0_oe)
    else $error("bad power-up state");

  a_pd_outputs_hiz: assert property (@(posedge clk) disable iff (!rstn)
    !normal_ff |-> !analog_out_0_oe && !analog_out_1_oe)
    else $error("converter driven in power-down");

  a_cmd_power_down_enter_enter: assert property (@(posedge clk) disable iff (!rstn)
    exec && op_ff == OP_CMD_POWER_DOWN_ENTER |=> !normal_ff [*2])
    else $error("power-down not entered");

  a_pd_exit_keep: assert property (@(posedge clk) disable iff (!rstn)
    s_pd_exit |=> normal_ff && $stable(dac0_ff) && $stable(dac1_ff))
    else $error("codes changed on power-down exit");

  a_wr0_dac: assert property (@(posedge clk) disable iff (!rstn)
    exec && normal_ff && op_ff == OP_WRITE && adr_ff == ADR_DAC
    |=> dac0_ff == $past(dat_ff[15:8]) && dac1_ff == $past(dat_ff[7:0]))
    else $error("word 0 write did not set outputs");

  a_call_pd_ignored: assert property (@(posedge clk) disable iff (!rstn)
    exec && op_ff == OP_CALL && !normal_ff |=> $stable(dac0_ff) && $stable(dac1_ff))
    else $error("recall acted in power-down");

  a_restore_load: assert property (@(posedge clk) disable iff (!rstn)
    restore_end |=> normal_ff && dac0_ff === $past(mem[ADR_DAC][15:8])
    && dac1_ff === $past(mem[ADR_DAC][7:0]))
    else $error("restore did not load word 0");

  // Status may only appear once a write has been taken, never while restoring
  a_restore_quiet: assert property (@(posedge clk) disable iff (!rstn)
    state_ff == S_RESTORE |-> !st_oe_ff)
    else $error("status driven during restore");

  a_restore_bound: assert property (@(posedge clk) disable iff (!rstn)
    state_ff == S_RESTORE |-> tcnt_ff <= RST_LAST)
    else $error("restore overran its time");

  a_restore_once: assert property (@(posedge clk) disable iff (!rstn)
    state_ff != S_WAIT_CS && state_ff != S_RESTORE |=> state_ff != S_RESTORE)
    else $error("restore ran twice");

  a_prog_busy: assert property (@(posedge clk) disable iff (!rstn)
    s_prog_go |=> s_busy_shown ##0 st_oe_ff)
    else $error("busy not shown after write");

  a_rd_window: assert property (@(negedge serial_clock) disable iff (chip_select_n)
    rd_oe_ff |-> cnt_ff >= BIT_RD_FIRST && op_ff == OP_READ)
    else $error("read data out of window");
endmodule
`default_nettype wire

// ---- verification/stdac_host.sv ----
`timescale 1ns/1ps
`default_nettype none
module stdac_host (
  output logic serial_clock,
  output logic chip_select_n,
  output logic data_in_pin,
  input wire logic data_out_pin,
  input wire logic data_out_oe
);
  logic [31:0] rd_ff;
  initial begin
    serial_clock = 1'b0;
    chip_select_n = 1'b1;
    data_in_pin = 1'b0;
    rd_ff = '0;
  end
  // Clock stands low outside frames; spare bits invert so stale data never looks valid
  task automatic xfer(input logic [31:0] bits, input int n, input int k);
    chip_select_n = 1'b0;
    #16;
    for (int i = 0; i < n + k; i++) begin
      data_in_pin = (i < n) ? bits[31-i] : ~data_in_pin;
      #16 serial_clock = 1'b1;
      // A released line reads inverted, so a sample outside the drive window shows up
      rd_ff = {rd_ff[30:0], data_out_oe ? data_out_pin : ~data_out_pin};
      #16 serial_clock = 1'b0;
    end
  endtask
  task automatic desel();
    chip_select_n = 1'b1;
    data_in_pin = ~data_in_pin;
    #80;
  endtask
endmodule
`default_nettype wire

// ---- verification/serial_trim_dac_eeprom_ctrl_tb.sv ----
`timescale 1ns/1ps
`default_nettype none
module serial_trim_dac_eeprom_ctrl_tb;
  import stdac_pkg::*;
  localparam int RC = 50;
  localparam int PC = 40;
  logic clk, rstn, sck, cs_n, din, dout, dout_oe, a0_oe, a1_oe;
  logic [7:0] a0, a1;
  logic [31:0] seed;
  logic [15:0] w5, w255, w0;
  int err_count, compares;
  int cyc = 0;

  initial clk = 1'b0;
  always #2 clk = ~clk;

  stdac_ctrl #(.RESTORE_CYCLES(RC), .PROG_CYCLES(PC)) dut (
    .clk(clk), .rstn(rstn), .serial_clock(sck), .chip_select_n(cs_n), .data_in_pin(din),
    .data_out_pin(dout), .data_out_oe(dout_oe), .analog_out_0(a0), .analog_out_0_oe(a0_oe),
    .analog_out_1(a1), .analog_out_1_oe(a1_oe)
  );
  stdac_host host (
    .serial_clock(sck), .chip_select_n(cs_n), .data_in_pin(din),
    .data_out_pin(dout), .data_out_oe(dout_oe)
  );

  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] x;
    x = s ^ (s << 13);
    x = x ^ (x >> 17);
    return x ^ (x << 5);
  endfunction
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    compares++;
    if (got !== exp) begin
      err_count++;
      $display("BAD t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic give_verdict();
    $display("compares %0d mismatches %0d", compares, err_count);
    if (err_count == 0 && compares > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  task automatic clks(input int n);
    repeat (n) @(negedge clk);
  endtask
  task automatic cmd(input logic [7:0] op, input logic [7:0] adr);
    host.xfer({op, adr, 16'h0000}, 16, 0);
    host.desel();
  endtask
  task automatic rd(input logic [7:0] adr, input int k);
    // First bit is driven at falling edge 17, so the host first sees it at rise 18
    host.xfer({OP_READ, adr, 16'h0000}, 16, k + 1);
    host.desel();
  endtask
  // Accepted write: busy low first, ready high once programming ends
  task automatic wrp(input logic [7:0] adr, input logic [15:0] d);
    host.xfer({OP_WRITE, adr, d}, 32, 0);
    clks(8);
    chk({14'h0, dout_oe, dout}, 16'h0002);
    clks(PC + 10);
    chk({14'h0, dout_oe, dout}, 16'h0003);
    host.desel();
  endtask
  // Refused write: no status ever driven
  task automatic wrx(input logic [7:0] adr, input logic [15:0] d);
    host.xfer({OP_WRITE, adr, d}, 32, 0);
    clks(10);
    chk({15'h0, dout_oe}, 16'h0000);
    host.desel();
  endtask

  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      err_count++;
      give_verdict();
    end
  end

  initial begin
    rstn = 1'b0;
    err_count = 0;
    compares = 0;
    seed = 32'he30c0bd0;
    seed = xs(seed);
    w5 = seed[15:0];
    seed = xs(seed);
    w255 = seed[15:0];
    seed = xs(seed);
    w0 = seed[31:16];
    clks(20);
    rstn = 1'b1;
    clks(4);
    chk({14'h0, a0_oe, a1_oe}, 16'h0000);
    // First low period carries a write enable and clocks the device must ignore
    host.xfer({OP_CMD_WRITE_ENABLE, 24'h0}, 16, 60);
    chk({15'h0, dout_oe}, 16'h0000);
    host.desel();
    chk({14'h0, a0_oe, a1_oe}, 16'h0003);
    $display("restore done");
    wrx(8'h05, w5);
    cmd(OP_CMD_WRITE_ENABLE, 8'h00);
    wrp(8'h05, w5);
    wrp(8'hff, w255);
    wrp(8'h00, w0);
    chk({a0, a1}, w0);
    $display("writes done");
    rd(8'hff, 32);
    chk(host.rd_ff[31:16], w255);
    chk(host.rd_ff[15:0], w0);
    chk({15'h0, dout_oe}, 16'h0000);
    $display("sequential read done");
    cmd(OP_CMD_WRITE_DISABLE, 8'h00);
    wrx(8'h05, ~w5);
    rd(8'h05, 16);
    chk(host.rd_ff[15:0], w5);
    $display("protection done");
    cmd(OP_CALL, 8'h05);
    chk({a0, a1}, w5);
    cmd(OP_CMD_POWER_DOWN_ENTER, 8'h00);
    chk({14'h0, a0_oe, a1_oe}, 16'h0000);
    cmd(OP_CALL, 8'hff);
    cmd(OP_CMD_WRITE_ENABLE, 8'h00);
    wrp(8'h00, w255);
    chk({14'h0, a0_oe, a1_oe}, 16'h0000);
    cmd(OP_CMD_POWER_DOWN_EXIT, 8'h00);
    chk({a0, a1}, w5);
    chk({14'h0, a0_oe, a1_oe}, 16'h0003);
    rd(8'h00, 16);
    chk(host.rd_ff[15:0], w255);
    $display("power-down done");
    // Cut-off disable frame must leave writes permitted
    host.xfer({OP_CMD_WRITE_DISABLE, 24'h0}, 12, 0);
    host.desel();
    wrp(8'h05, w0);
    $display("partial frame done");
    // Second power application: word 0 reloads, write permission drops
    clks(1);
    rstn = 1'b0;
    clks(20);
    rstn = 1'b1;
    clks(4);
    chk({14'h0, a0_oe, a1_oe}, 16'h0000);
    host.xfer({OP_CMD_WRITE_ENABLE, 24'h0}, 16, 60);
    host.desel();
    chk({a0, a1}, w255);
    wrx(8'h05, w5);
    rd(8'h05, 16);
    chk(host.rd_ff[15:0], w0);
    $display("second power-up done");
    give_verdict();
  end
endmodule
`default_nettype wire
